// ==== core/pdu_regs.svh ====
// register offsets, command fields and unit codes of the peripheral dma channel
`ifndef PDU_REGS_SVH
`define PDU_REGS_SVH
`define PDU_RX_CUR_PTR_OFF 12'h100
`define PDU_RX_CUR_CNT_OFF 12'h104
`define PDU_TX_CUR_PTR_OFF 12'h108
`define PDU_TX_CUR_CNT_OFF 12'h10c
`define PDU_RX_NXT_PTR_OFF 12'h110
`define PDU_RX_NXT_CNT_OFF 12'h114
`define PDU_TX_NXT_PTR_OFF 12'h118
`define PDU_TX_NXT_CNT_OFF 12'h11c
`define PDU_XFER_CTRL_OFF 12'h120
`define PDU_XFER_STATE_OFF 12'h124
`define PDU_PTR_RESET 32'h0
`define PDU_CNT_RESET 16'h0
`define PDU_RX_EN_BIT 0
`define PDU_RX_DIS_BIT 1
`define PDU_TX_EN_BIT 8
`define PDU_TX_DIS_BIT 9
`define PDU_UNIT_BYTE 2'h0
`define PDU_UNIT_HALF 2'h1
`define PDU_STEP_BYTE 32'h1
`define PDU_STEP_HALF 32'h2
`define PDU_STEP_WORD 32'h4
`define PDU_CNT_ONE 16'h1
`endif

// ==== core/pdu_pkg.sv ====
// types of the peripheral dma channel
package pdu_pkg;
	typedef enum logic [6:0] {
		PDU_IDLE = 7'h01,
		PDU_REQ = 7'h02,
		PDU_RXRD = 7'h04,
		PDU_MWR = 7'h08,
		PDU_MRD = 7'h10,
		PDU_TXWR = 7'h20,
		PDU_UPD = 7'h40
	} pdu_state_t;
endpackage : pdu_pkg

// ==== core/pdu_channel.sv ====
// peripheral dma channel: pointers, counters, transfer engine and flags
// Operation
// - 32-bit pointers, 16-bit counters, current and next per direction.
// - full duplex programs both parts; half duplex one part at a time.
// - remaining counts readable at any moment, also mid-transfer.
// - pointer advances 1, 2 or 4 bytes per unit size.
// - pointer rewritten mid-transfer: continue from new address.
// - current counter decrements once per unit moved.
// - current and next both zero: stop and raise completion flag.
// - current zero, next nonzero: copy next into current, clear next, resume.
// - zero count halts; nonzero count starts if requests enabled.
// - receive end flag on rx count zero; cleared by nonzero rx count write.
// - receive full flag on both rx zero; cleared by nonzero tx count write.
// - transmit end flag on tx count zero; cleared by nonzero tx count write.
// - transmit empty flag on both tx zero; cleared by nonzero tx count write.
// - rx ready: request bus, read holding data, buffer, write memory.
// - tx ready: request bus, read memory, write holding register.
// - completion flags only go to the peripheral status, no own register.
// - enable set/clear commands; enabled state readable in state register.
// - half duplex: rx and tx names reach the same registers.
// - enable unless disable also written; disable wins; zero bits ignored.
// - half duplex: rx enable drops tx; any disable drops both.
module pdu_channel #(
	parameter int HALF_DUPLEX = 0,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// peripheral side
	input wire logic rx_ready,
	input wire logic [31:0] rx_hold_data,
	output logic rx_hold_rd,
	input wire logic tx_ready,
	output logic [31:0] tx_hold_data,
	output logic tx_hold_wr,
	input wire logic [1:0] unit_size,
	// flags to the peripheral status register
	output logic receive_end_flag,
	output logic receive_buffer_full_flag,
	output logic transmit_end_flag,
	output logic transmit_buffer_empty_flag,
	// memory side through the bus matrix
	output logic bus_req,
	input wire logic bus_grant,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic mem_wr,
	output logic [31:0] mem_wdata,
	output logic mem_rd,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack
);
`include "pdu_regs.svh"

	localparam int NCH = (HALF_DUPLEX != 0) ? 1 : 2;
	localparam int TXI = (HALF_DUPLEX != 0) ? 0 : 1;

	if (ADDR_W < 9 || ADDR_W > 32) begin : g_chk_addr
		$error("pdu_channel: ADDR_W must lie in 9..32");
	end
	if (HALF_DUPLEX != 0 && HALF_DUPLEX != 1) begin : g_chk_half
		$error("pdu_channel: HALF_DUPLEX must be 0 or 1");
	end

	////////////////////////////////////////////////////////////////////////////////
	// storage: index 0 receive, index 1 transmit; half duplex shares index 0

	logic [31:0] cur_ptr [NCH];
	logic [15:0] cur_cnt [NCH];
	logic [31:0] nxt_ptr [NCH];
	logic [15:0] nxt_cnt [NCH];
	logic rx_en;
	logic tx_en;
	logic dir_tx;
	pdu_pkg::pdu_state_t state;
	pdu_pkg::pdu_state_t next_state;

	wire [11:0] a = 12'(reg_addr);
	wire hit_rcp = a == `PDU_RX_CUR_PTR_OFF;
	wire hit_rcc = a == `PDU_RX_CUR_CNT_OFF;
	wire hit_tcp = a == `PDU_TX_CUR_PTR_OFF;
	wire hit_tcc = a == `PDU_TX_CUR_CNT_OFF;
	wire hit_rnp = a == `PDU_RX_NXT_PTR_OFF;
	wire hit_rnc = a == `PDU_RX_NXT_CNT_OFF;
	wire hit_tnp = a == `PDU_TX_NXT_PTR_OFF;
	wire hit_tnc = a == `PDU_TX_NXT_CNT_OFF;
	wire hit_ctl = a == `PDU_XFER_CTRL_OFF;
	wire hit_sts = a == `PDU_XFER_STATE_OFF;

	wire wr_nz = reg_wr && reg_wdata[15:0] != 16'h0;
	wire nz_rx_cnt = wr_nz && (hit_rcc || hit_rnc);
	wire nz_tx_cnt = wr_nz && (hit_tcc || hit_tnc);

	// one channel index per direction; half duplex folds both onto 0
	wire sel = dir_tx && (HALF_DUPLEX == 0);
	wire [15:0] cnt_sel = cur_cnt[sel];
	wire [15:0] nxt_sel = nxt_cnt[sel];
	wire upd = state == pdu_pkg::PDU_UPD;
	wire last_unit = upd && cnt_sel == `PDU_CNT_ONE;
	wire buf_done = last_unit && nxt_sel == 16'h0;

	wire [31:0] step = (unit_size == `PDU_UNIT_BYTE) ? `PDU_STEP_BYTE :
		(unit_size == `PDU_UNIT_HALF) ? `PDU_STEP_HALF : `PDU_STEP_WORD;

	////////////////////////////////////////////////////////////////////////////////
	// pointer and counter registers

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		wire is_rx = i == 0;
		wire is_tx = i == TXI;
		wire w_cp = reg_wr && ((hit_rcp && is_rx) || (hit_tcp && is_tx));
		wire w_cc = reg_wr && ((hit_rcc && is_rx) || (hit_tcc && is_tx));
		wire w_np = reg_wr && ((hit_rnp && is_rx) || (hit_tnp && is_tx));
		wire w_nc = reg_wr && ((hit_rnc && is_rx) || (hit_tnc && is_tx));
		wire my_upd = upd && (32'(sel) == i);
		wire reload = my_upd && cur_cnt[i] == `PDU_CNT_ONE && nxt_cnt[i] != 16'h0;

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cur_ptr[i] <= `PDU_PTR_RESET;
				cur_cnt[i] <= `PDU_CNT_RESET;
				nxt_ptr[i] <= `PDU_PTR_RESET;
				nxt_cnt[i] <= `PDU_CNT_RESET;
			end else begin
				if (reload) begin
					cur_ptr[i] <= nxt_ptr[i];
					cur_cnt[i] <= nxt_cnt[i];
					nxt_ptr[i] <= `PDU_PTR_RESET;
					nxt_cnt[i] <= `PDU_CNT_RESET;
				end else if (my_upd) begin
					cur_ptr[i] <= cur_ptr[i] + step;
					cur_cnt[i] <= cur_cnt[i] - `PDU_CNT_ONE;
				end
				// software wins over the engine, so a new address is taken at once
				if (w_cp) begin
					cur_ptr[i] <= reg_wdata;
				end
				if (w_cc) begin
					cur_cnt[i] <= reg_wdata[15:0];
				end
				if (w_np) begin
					nxt_ptr[i] <= reg_wdata;
				end
				if (w_nc) begin
					nxt_cnt[i] <= reg_wdata[15:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request enables

	wire c_rx_en = reg_wr && hit_ctl && reg_wdata[`PDU_RX_EN_BIT];
	wire c_rx_dis = reg_wr && hit_ctl && reg_wdata[`PDU_RX_DIS_BIT];
	wire c_tx_en = reg_wr && hit_ctl && reg_wdata[`PDU_TX_EN_BIT];
	wire c_tx_dis = reg_wr && hit_ctl && reg_wdata[`PDU_TX_DIS_BIT];
	wire any_dis = c_rx_dis || c_tx_dis;
	wire next_rx_en = (HALF_DUPLEX != 0) ?
		(any_dis ? 1'b0 : (c_rx_en ? 1'b1 : rx_en)) :
		(c_rx_dis ? 1'b0 : (c_rx_en ? 1'b1 : rx_en));
	wire next_tx_en = (HALF_DUPLEX != 0) ?
		(any_dis || c_rx_en ? 1'b0 : (c_tx_en ? 1'b1 : tx_en)) :
		(c_tx_dis ? 1'b0 : (c_tx_en ? 1'b1 : tx_en));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_en <= 1'b0;
			tx_en <= 1'b0;
		end else begin
			rx_en <= next_rx_en;
			tx_en <= next_tx_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer engine

	// a zero count blocks the start, so writing zero halts that direction
	wire rx_go = rx_en && rx_ready && cur_cnt[0] != 16'h0;
	wire tx_go = tx_en && tx_ready && cur_cnt[TXI] != 16'h0;

	always_comb begin
		next_state = state;
		case (state)
			pdu_pkg::PDU_IDLE: begin
				if (rx_go || tx_go) begin
					next_state = pdu_pkg::PDU_REQ;
				end
			end
			pdu_pkg::PDU_REQ: begin
				if (bus_grant) begin
					next_state = dir_tx ? pdu_pkg::PDU_MRD : pdu_pkg::PDU_RXRD;
				end
			end
			pdu_pkg::PDU_RXRD: next_state = pdu_pkg::PDU_MWR;
			pdu_pkg::PDU_MWR: begin
				if (mem_ack) begin
					next_state = pdu_pkg::PDU_UPD;
				end
			end
			pdu_pkg::PDU_MRD: begin
				if (mem_ack) begin
					next_state = pdu_pkg::PDU_TXWR;
				end
			end
			pdu_pkg::PDU_TXWR: next_state = pdu_pkg::PDU_UPD;
			pdu_pkg::PDU_UPD: next_state = pdu_pkg::PDU_IDLE;
			default: next_state = pdu_pkg::PDU_IDLE;
		endcase
	end

	wire next_busy = next_state != pdu_pkg::PDU_IDLE && next_state != pdu_pkg::PDU_UPD;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= pdu_pkg::PDU_IDLE;
			dir_tx <= 1'b0;
			bus_req <= 1'b0;
			rx_hold_rd <= 1'b0;
			tx_hold_wr <= 1'b0;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
		end else begin
			state <= next_state;
			if (state == pdu_pkg::PDU_IDLE) begin
				dir_tx <= !rx_go; // receive first when both are ready
			end
			bus_req <= next_busy;
			rx_hold_rd <= next_state == pdu_pkg::PDU_RXRD;
			tx_hold_wr <= next_state == pdu_pkg::PDU_TXWR;
			mem_wr <= next_state == pdu_pkg::PDU_MWR;
			mem_rd <= next_state == pdu_pkg::PDU_MRD;
		end
	end

	// data path: the write data register is the receive buffer itself
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_addr <= 32'h0;
			mem_size <= 2'h0;
			mem_wdata <= 32'h0;
			tx_hold_data <= 32'h0;
		end else begin
			mem_addr <= cur_ptr[sel];
			mem_size <= unit_size;
			if (state == pdu_pkg::PDU_RXRD) begin
				mem_wdata <= rx_hold_data;
			end
			if (state == pdu_pkg::PDU_MRD && mem_ack) begin
				tx_hold_data <= mem_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// completion flags, wired only toward the peripheral status register

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			receive_end_flag <= 1'b0;
			receive_buffer_full_flag <= 1'b0;
			transmit_end_flag <= 1'b0;
			transmit_buffer_empty_flag <= 1'b0;
		end else begin
			// a set in the clearing cycle is kept
			receive_end_flag <= (last_unit && !dir_tx) || (receive_end_flag && !nz_rx_cnt);
			receive_buffer_full_flag <= (buf_done && !dir_tx) ||
				(receive_buffer_full_flag && !nz_tx_cnt);
			transmit_end_flag <= (last_unit && dir_tx) || (transmit_end_flag && !nz_tx_cnt);
			transmit_buffer_empty_flag <= (buf_done && dir_tx) ||
				(transmit_buffer_empty_flag && !nz_tx_cnt);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read, data one cycle after the strobe

	logic [31:0] rd_val;
	always_comb begin
		if (hit_rcp) begin
			rd_val = cur_ptr[0];
		end else if (hit_rcc) begin
			rd_val = {16'h0, cur_cnt[0]};
		end else if (hit_tcp) begin
			rd_val = cur_ptr[TXI];
		end else if (hit_tcc) begin
			rd_val = {16'h0, cur_cnt[TXI]};
		end else if (hit_rnp) begin
			rd_val = nxt_ptr[0];
		end else if (hit_rnc) begin
			rd_val = {16'h0, nxt_cnt[0]};
		end else if (hit_tnp) begin
			rd_val = nxt_ptr[TXI];
		end else if (hit_tnc) begin
			rd_val = {16'h0, nxt_cnt[TXI]};
		end else if (hit_sts) begin
			rd_val = {23'h0, tx_en, 7'h0, rx_en};
		end else begin
			rd_val = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_val : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_rx_grant;
		state == pdu_pkg::PDU_REQ && bus_grant && !dir_tx;
	endsequence
	sequence s_rx_moves;
		rx_hold_rd ##1 mem_wr;
	endsequence
	sequence s_tx_grant;
		state == pdu_pkg::PDU_REQ && bus_grant && dir_tx;
	endsequence
	wire upd_rx_mid = upd && !dir_tx && cur_cnt[0] > `PDU_CNT_ONE && !reg_wr;

	chk_req_hold: assert property (bus_req && !bus_grant |=> bus_req)
		else $error("bus request dropped before grant");
	chk_rx_path: assert property (s_rx_grant |=> s_rx_moves)
		else $error("receive path order wrong");
	chk_tx_path: assert property (s_tx_grant |=> mem_rd ##[1:20] tx_hold_wr)
		else $error("transmit path order wrong");
	chk_ptr_step: assert property (upd_rx_mid |=> cur_ptr[0] == $past(cur_ptr[0]) + $past(step))
		else $error("pointer step wrong");
	chk_cnt_dec: assert property (upd_rx_mid |=> cur_cnt[0] == $past(cur_cnt[0]) - `PDU_CNT_ONE)
		else $error("counter decrement wrong");
	chk_next_load: assert property (upd && !dir_tx && cur_cnt[0] == `PDU_CNT_ONE && nxt_cnt[0] != 16'h0 &&
		!reg_wr |=> cur_cnt[0] == $past(nxt_cnt[0]) && nxt_cnt[0] == 16'h0)
		else $error("next pair not moved");
	chk_stop_flag: assert property (buf_done && !dir_tx |=> receive_buffer_full_flag && receive_end_flag &&
		state == pdu_pkg::PDU_IDLE)
		else $error("stop flags missing");
	chk_dis_prio: assert property (c_rx_dis |=> !rx_en)
		else $error("disable lost to enable");
	chk_cnt_read: assert property (reg_rd && hit_rcc |=> reg_rdata[15:0] == $past(cur_cnt[0]))
		else $error("count read wrong");
	chk_zero_halt: assert property (state == pdu_pkg::PDU_IDLE && cur_cnt[0] == 16'h0 &&
		cur_cnt[TXI] == 16'h0 |=> !bus_req)
		else $error("moved with zero count");
	chk_flag_clr: assert property (nz_tx_cnt && !(last_unit && dir_tx) |=> !transmit_end_flag)
		else $error("transmit end flag not cleared");

endmodule : pdu_channel

// ==== bench/pdu_far_end.sv ====
// far side model: serial peripheral holding registers and memory behind the matrix
module pdu_far_end (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// peripheral side
	output logic rx_ready,
	output logic [31:0] rx_hold_data,
	input wire logic rx_hold_rd,
	output logic tx_ready,
	input wire logic tx_hold_wr,
	// memory side
	input wire logic bus_req,
	output logic bus_grant,
	input wire logic [31:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [2:0] rx_wait;
	logic [2:0] tx_wait;
	logic [1:0] ack_wait;
	logic [31:0] noise;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_ready <= 1'b0;
			rx_hold_data <= 32'h10;
			tx_ready <= 1'b0;
			bus_grant <= 1'b0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			rx_wait <= 3'h0;
			tx_wait <= 3'h0;
			ack_wait <= 2'h0;
			noise <= 32'h0;
		end else begin
			noise <= noise + 32'h9e3779b9;
			// next datum arrives a few cycles after the last one is taken
			if (rx_hold_rd) begin
				rx_hold_data <= rx_hold_data + 32'h1;
				rx_ready <= 1'b0;
				rx_wait <= 3'($urandom_range(3, 1));
			end else if (rx_wait != 3'h0) rx_wait <= rx_wait - 3'h1;
			else rx_ready <= 1'b1;
			// shifter busy for a while after each load
			if (tx_hold_wr) begin
				tx_ready <= 1'b0;
				tx_wait <= 3'h6;
			end else if (tx_wait != 3'h0) tx_wait <= tx_wait - 3'h1;
			else tx_ready <= 1'b1;
			// grant may be late, then stays while requested
			bus_grant <= bus_req && (bus_grant || $urandom_range(2, 0) == 0);
			mem_ack <= 1'b0;
			// data bus garbage outside the ack cycle
			mem_rdata <= noise;
			if ((mem_rd || mem_wr) && !mem_ack) begin
				if (ack_wait == 2'h0) begin
					mem_ack <= 1'b1;
					mem_rdata <= ~mem_addr;
					ack_wait <= 2'($urandom_range(3, 0));
				end else ack_wait <= ack_wait - 2'h1;
			end
		end
	end
endmodule : pdu_far_end

// ==== bench/pdu_channel_test.sv ====
// self-checking bench of the peripheral dma channel
`include "pdu_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module pdu_channel_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic sys_rst;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rx_hold_data, tx_hold_data, mem_addr, mem_wdata, mem_rdata, e32;
	logic reg_wr, reg_rd, rx_ready, rx_hold_rd, tx_ready, tx_hold_wr, bus_req, bus_grant, mem_wr, mem_rd, mem_ack;
	logic [1:0] unit_size, mem_size;
	logic receive_end_flag, receive_buffer_full_flag, transmit_end_flag, transmit_buffer_empty_flag;
	logic rd_d = 1'b0;
	logic [65:0] e66;
	int failures = 0;
	int total_checks = 0;
	logic [31:0] rd_q[$];
	logic [31:0] tx_q[$];
	logic [65:0] mw_q[$];
	logic [31:0] seq = 32'h10;
	logic [31:0] cw[6] = '{32'h101, 32'h3, 32'h0, 32'h300, 32'h1, 32'h2};
	logic [31:0] st[6] = '{32'h101, 32'h100, 32'h100, 32'h0, 32'h1, 32'h0};
	logic reg_rd_h = 1'b0;
	logic hd_on = 1'b0;
	logic hd_d = 1'b0;
	logic [31:0] hd_rdata;
	logic [31:0] hd_q[$];
	logic [31:0] cw2[5] = '{32'h100, 32'h1, 32'h200, 32'h100, 32'h2};
	logic [31:0] st2[5] = '{32'h100, 32'h1, 32'h0, 32'h100, 32'h0};

	pdu_channel #(.HALF_DUPLEX(0), .ADDR_W(12)) pdu_channel_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_ready, .rx_hold_data, .rx_hold_rd, .tx_ready, .tx_hold_data, .tx_hold_wr, .unit_size,
		.receive_end_flag, .receive_buffer_full_flag, .transmit_end_flag, .transmit_buffer_empty_flag, .bus_req,
		.bus_grant, .mem_addr, .mem_size, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata, .mem_ack);
	pdu_far_end pdu_far_end_inst (.clk, .sys_rst, .rx_ready, .rx_hold_data, .rx_hold_rd, .tx_ready, .tx_hold_wr,
		.bus_req, .bus_grant, .mem_addr, .mem_wr, .mem_rd, .mem_rdata, .mem_ack);
	// half duplex twin; writes reach it only during its own phase
	if (1) begin : g_half
		pdu_channel #(.HALF_DUPLEX(1), .ADDR_W(12)) pdu_channel_inst (.clk(clk), .sys_rst(sys_rst),
			.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr && hd_on), .reg_rd(reg_rd_h),
			.reg_rdata(hd_rdata), .rx_ready(rx_ready), .rx_hold_data(rx_hold_data), .rx_hold_rd(),
			.tx_ready(tx_ready), .tx_hold_data(), .tx_hold_wr(), .unit_size(unit_size), .receive_end_flag(),
			.receive_buffer_full_flag(), .transmit_end_flag(), .transmit_buffer_empty_flag(), .bus_req(),
			.bus_grant(bus_grant), .mem_addr(), .mem_size(), .mem_wr(), .mem_wdata(), .mem_rd(),
			.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task end_sim;
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rd_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd

	task hrd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_h <= 1'b1;
		hd_q.push_back(e);
		@(posedge clk);
		reg_rd_h <= 1'b0;
	endtask : hrd

	// bounded wait, a missing event shows up in the checks after it
	task automatic wait_hi(ref logic f);
		for (int i = 0; i < 300 && f !== 1'b1; i++) @(negedge clk);
	endtask : wait_hi

	task automatic rx_run(input logic [1:0] s);
		logic [31:0] p, q, stp;
		p = $urandom & 32'hfffffffc;
		q = $urandom & 32'hfffffffc;
		stp = 32'h1 << s;
		unit_size <= s;
		wr(`PDU_RX_CUR_PTR_OFF, p);
		wr(`PDU_RX_CUR_CNT_OFF, 32'hffff0002);
		wr(`PDU_RX_NXT_PTR_OFF, q);
		wr(`PDU_RX_NXT_CNT_OFF, 32'h1);
		mw_q.push_back({s, p, seq});
		mw_q.push_back({s, p + stp, seq + 32'h1});
		mw_q.push_back({s, q, seq + 32'h2});
		seq = seq + 32'h3;
		wr(`PDU_XFER_CTRL_OFF, 32'h1);
		wait_hi(receive_buffer_full_flag);
		`CHK("rx_end", 1'b1, receive_end_flag)
		`CHK("rx_full", 1'b1, receive_buffer_full_flag)
		rd(`PDU_RX_CUR_CNT_OFF, 32'h0);
		rd(`PDU_RX_NXT_CNT_OFF, 32'h0);
		rd(`PDU_RX_NXT_PTR_OFF, 32'h0);
		rd(`PDU_RX_CUR_PTR_OFF, q + stp);
		wr(`PDU_XFER_CTRL_OFF, 32'h2);
		wr(`PDU_TX_CUR_CNT_OFF, 32'h5);
		repeat (2) @(negedge clk);
		`CHK("rx_full", 1'b0, receive_buffer_full_flag)
		`CHK("rx_end", 1'b1, receive_end_flag)
		wr(`PDU_TX_CUR_CNT_OFF, 32'h0);
		wr(`PDU_RX_NXT_CNT_OFF, 32'h3);
		repeat (2) @(negedge clk);
		`CHK("rx_end", 1'b0, receive_end_flag)
		wr(`PDU_RX_NXT_CNT_OFF, 32'h0);
	endtask : rx_run

	// result monitor, oldest note first
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) begin
			e32 = rd_q.pop_front();
			`CHK("reg_rdata", e32, reg_rdata)
		end
		hd_d <= reg_rd_h;
		if (hd_d) begin
			e32 = hd_q.pop_front();
			`CHK("hd_rdata", e32, hd_rdata)
		end
		if (mem_wr && mem_ack) begin
			e66 = mw_q.pop_front();
			`CHK("mem_write", e66, {mem_size, mem_addr, mem_wdata})
		end
		if (tx_hold_wr) begin
			e32 = tx_q.pop_front();
			`CHK("tx_hold", e32, tx_hold_data)
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		end_sim;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d, r, n;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		unit_size = 2'h0;
		sys_rst = 1'b1;
		void'($urandom(32'hdefa));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values; control, unmapped and write-only places read zero
		wr(12'h200, 32'hffffffff);
		for (int i = 0; i < 11; i++) rd(12'h100 + 12'(i * 4), 32'h0);
		rd(12'h200, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			wr(12'h100 + 12'(i * 4), d);
			rd(12'h100 + 12'(i * 4), i[0] ? {16'h0, d[15:0]} : d);
		end
		for (int i = 1; i < 8; i += 2) wr(12'h100 + 12'(i * 4), 32'h0);
		for (int i = 0; i < 6; i++) begin
			wr(`PDU_XFER_CTRL_OFF, cw[i]);
			rd(`PDU_XFER_STATE_OFF, st[i]);
		end
		// enabled with zero counts: any transfer is an unexpected note
		wr(`PDU_XFER_CTRL_OFF, 32'h101);
		repeat (30) @(posedge clk);
		wr(`PDU_XFER_CTRL_OFF, 32'h202);
		for (int s = 0; s < 3; s++) rx_run(2'(s));
		// transmit with pointer moved after the first unit
		r = $urandom & 32'hfffffffc;
		n = $urandom & 32'hfffffffc;
		unit_size <= 2'h2;
		wr(`PDU_TX_CUR_PTR_OFF, r);
		wr(`PDU_TX_CUR_CNT_OFF, 32'h3);
		tx_q.push_back(~r);
		tx_q.push_back(~n);
		tx_q.push_back(~(n + 32'h4));
		wr(`PDU_XFER_CTRL_OFF, 32'h100);
		wait_hi(tx_hold_wr);
		wr(`PDU_TX_CUR_PTR_OFF, n);
		wait_hi(transmit_buffer_empty_flag);
		`CHK("tx_end", 1'b1, transmit_end_flag)
		`CHK("tx_empty", 1'b1, transmit_buffer_empty_flag)
		rd(`PDU_TX_CUR_PTR_OFF, n + 32'h8);
		wr(`PDU_XFER_CTRL_OFF, 32'h200);
		wr(`PDU_TX_NXT_CNT_OFF, 32'h1);
		repeat (2) @(negedge clk);
		`CHK("tx_end", 1'b0, transmit_end_flag)
		`CHK("tx_empty", 1'b0, transmit_buffer_empty_flag)
		// half duplex twin: both names reach one register set, enables interlock
		hd_on <= 1'b1;
		d = $urandom;
		wr(`PDU_RX_CUR_PTR_OFF, d);
		hrd(`PDU_TX_CUR_PTR_OFF, d);
		wr(`PDU_TX_CUR_CNT_OFF, d);
		hrd(`PDU_RX_CUR_CNT_OFF, {16'h0, d[15:0]});
		wr(`PDU_TX_NXT_PTR_OFF, ~d);
		hrd(`PDU_RX_NXT_PTR_OFF, ~d);
		wr(`PDU_TX_CUR_CNT_OFF, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(`PDU_XFER_CTRL_OFF, cw2[i]);
			hrd(`PDU_XFER_STATE_OFF, st2[i]);
		end
		repeat (10) @(posedge clk);
		`CHK("pending", 32'h0, 32'(mw_q.size() + tx_q.size() + rd_q.size() + hd_q.size()))
		end_sim;
	end
endmodule : pdu_channel_test
